// File: rtl/swt_regs.vh
`ifndef SWT_REGS_VH
`define SWT_REGS_VH
// Counter geometry
`define SWT_CNT_W 41
`define SWT_ROLL_VAL 41'h001FFFFFFFF
`define SWT_CNT_RST 41'h00000000000
// Rates: 32 kHz count unit, 16 MHz reference, 125 MHz system clock
`define SWT_CLK_HZ 125000000
`define SWT_SLOW_HZ 32000
`define SWT_REF_HZ 16000000
// Slow tick divider: 125 MHz / 32 kHz rounded down (3906)
`define SWT_SLOW_DIV 16'h0F42
// Reference tick as a fraction of the clock: 16 / 125 of 125 MHz is 16 MHz
`define SWT_REF_STEP 8'h10
`define SWT_REF_MOD 8'h7D
// Calibration window in slow periods, and reference ticks it spans (kept as a full count, not divided)
`define SWT_CAL_PERIODS 5'h14
`define SWT_CAL_SHIFT 5
`define SWT_CAL_NOMINAL 32'h00002710
`endif

// File: rtl/swt_counter.v
`include "swt_regs.vh"

module swt_counter (
  input wire clk_i,
  input wire reset_n_i,
  input wire tick_i,
  input wire start_i,
  input wire stop_i,
  input wire [`SWT_CNT_W-1:0] load_i,
  input wire int_en_i,
  output reg [`SWT_CNT_W-1:0] count_o,
  output reg active_o,
  output reg fire_o,
  output reg wake_en_o
);

  // Down count, reload on passing zero; stop wins over a running tick
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_o <= `SWT_CNT_RST;
      active_o <= 1'b0;
      fire_o <= 1'b0;
      wake_en_o <= 1'b0;
    end else begin
      fire_o <= 1'b0;
      if (stop_i) begin
        // [RULE5] Stop halts only
        active_o <= 1'b0;
      end else if (start_i) begin
        count_o <= load_i;
        active_o <= 1'b1;
        // [RULE4] Enable sampled at start
        wake_en_o <= int_en_i;
      end else if (active_o && tick_i) begin
        // [RULE1] Fire and roll over
        if (count_o == `SWT_CNT_RST) begin
          count_o <= `SWT_ROLL_VAL;
          fire_o <= 1'b1;
        end else begin
          count_o <= count_o - 1'b1;
        end
      end
    end
  end

endmodule // swt_counter

// File: rtl/swt_top.v
// Function
// [RULE1] Count down per tick, fire, reload all-ones (code reloads 41'h1FFFFFFFF, only the low 33 bits set)
// [RULE2] One count equals one 32 kHz period
// [RULE3] Software loads counts between two and maximum
// [RULE4] Set interrupt enable before starting timer
// [RULE5] Stop halts timer, keeps stored enable
// [RULE6] Stopping never raises interrupt or wake
// [RULE7] Reading value never disturbs the count
// [RULE8] Active bitmap, one bit per timer
// [RULE9] Active stays set through rollover until stop
// [RULE10] Fired bitmap sets on zero, read clears
// [RULE11] Calibrate timer zero over twenty slow periods
// [RULE12] Result 10000 nominal, larger when slow
// [RULE13] Two independent 41-bit counters
// [RULE14] Enabled expiry during sleep wakes device
// [RULE15] Writing enable while running stops timer
// [RULE16] Enabled fire holds interrupt request until acknowledged
`include "swt_regs.vh"

module swt_top (
  input wire clk_i,
  input wire reset_n_i,
  input wire [1:0] start_i,
  input wire [1:0] stop_i,
  input wire [`SWT_CNT_W-1:0] load_count_i,
  input wire [1:0] int_en_wr_i,
  input wire int_en_val_i,
  input wire fired_rd_i,
  input wire sleep_i,
  input wire [1:0] irq_ack_i,
  input wire cal_req_i,
  output reg [`SWT_CNT_W-1:0] sleep_counter_first_o,
  output reg [`SWT_CNT_W-1:0] sleep_counter_second_o,
  output reg [1:0] active_o,
  output reg [1:0] fired_o,
  output reg [1:0] irq_o,
  output reg wake_o,
  output reg cal_busy_o,
  output reg cal_done_o,
  output reg [31:0] cal_result_o
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ALIGN = 3'b010;
  localparam [2:0] ST_MEAS = 3'b100;
  localparam [15:0] SLOW_DIV = `SWT_SLOW_DIV;
  localparam [7:0] REF_STEP = `SWT_REF_STEP;
  localparam [7:0] REF_MOD = `SWT_REF_MOD;

  reg [15:0] slow_cnt_q;
  reg slow_tick_q;
  reg [7:0] ref_acc_q;
  reg ref_tick_q;
  wire [7:0] ref_sum_w;
  reg [1:0] int_en_q;
  reg [1:0] fired_q;
  reg [2:0] state_q;
  reg [4:0] cal_per_q;
  reg [31:0] cal_ref_q;
  reg cal_start_q;
  wire [1:0] run_w;
  wire [1:0] fire_w;
  wire [1:0] wake_en_w;
  wire [1:0] stop_w;
  wire [1:0] start_w;
  wire [`SWT_CNT_W-1:0] cnt_w [0:1];
  wire [`SWT_CNT_W-1:0] load_w [0:1];

  // [RULE2] Slow tick from divider
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      slow_cnt_q <= 16'h0000;
      slow_tick_q <= 1'b0;
    end else if (slow_cnt_q == SLOW_DIV - 16'h0001) begin
      slow_cnt_q <= 16'h0000;
      slow_tick_q <= 1'b1;
    end else begin
      slow_cnt_q <= slow_cnt_q + 16'h0001;
      slow_tick_q <= 1'b0;
    end
  end

  // Reference 16 MHz tick by fractional divide; exact mean rate, spacing jitters 7 or 8 clocks
  assign ref_sum_w = ref_acc_q + REF_STEP;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ref_acc_q <= 8'h00;
      ref_tick_q <= 1'b0;
    end else if (ref_sum_w >= REF_MOD) begin
      ref_acc_q <= ref_sum_w - REF_MOD;
      ref_tick_q <= 1'b1;
    end else begin
      ref_acc_q <= ref_sum_w;
      ref_tick_q <= 1'b0;
    end
  end

  // [RULE15] Enable write on running timer stops it
  assign stop_w = stop_i | (int_en_wr_i & run_w);
  // Calibration borrows timer zero with a maximum load
  assign start_w = start_i | {1'b0, cal_start_q};
  assign load_w[0] = cal_start_q ? `SWT_ROLL_VAL : load_count_i;
  assign load_w[1] = load_count_i;

  // [RULE13] Two independent counters
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_tmr
      swt_counter u_cnt (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .tick_i(slow_tick_q),
        .start_i(start_w[gi]),
        .stop_i(stop_w[gi]),
        .load_i(load_w[gi]),
        .int_en_i(int_en_q[gi]),
        .count_o(cnt_w[gi]),
        .active_o(run_w[gi]),
        .fire_o(fire_w[gi]),
        .wake_en_o(wake_en_w[gi])
      );

      // Stored enable survives stop; sampled by counter at start
      always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          int_en_q[gi] <= 1'b0;
        end else if (int_en_wr_i[gi]) begin
          int_en_q[gi] <= int_en_val_i;
        end
      end

      // [RULE10] Fire sets, read clears, set wins
      always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          fired_q[gi] <= 1'b0;
        end else if (fire_w[gi]) begin
          fired_q[gi] <= 1'b1;
        end else if (fired_rd_i) begin
          fired_q[gi] <= 1'b0;
        end
      end

      // [RULE16] Pending request until acknowledge
      always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          irq_o[gi] <= 1'b0;
        end else if (fire_w[gi] && wake_en_w[gi]) begin
          irq_o[gi] <= 1'b1;
        end else if (irq_ack_i[gi]) begin
          irq_o[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // [RULE7] Count mirrored without side effects
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sleep_counter_first_o <= `SWT_CNT_RST;
      sleep_counter_second_o <= `SWT_CNT_RST;
      active_o <= 2'b00;
      fired_o <= 2'b00;
      wake_o <= 1'b0;
    end else begin
      sleep_counter_first_o <= cnt_w[0];
      sleep_counter_second_o <= cnt_w[1];
      // [RULE8] [RULE9] Active bitmap
      active_o <= run_w;
      fired_o <= fired_q;
      // [RULE14] [RULE6] Wake only from enabled expiry
      wake_o <= sleep_i && |(fire_w & wake_en_w);
    end
  end

  // [RULE11] Calibration sequencer on timer zero
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_IDLE;
      cal_per_q <= 5'h00;
      cal_ref_q <= 32'h00000000;
      cal_start_q <= 1'b0;
      cal_busy_o <= 1'b0;
      cal_done_o <= 1'b0;
      cal_result_o <= 32'h00000000;
    end else begin
      cal_start_q <= 1'b0;
      cal_done_o <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (cal_req_i) begin
            cal_start_q <= 1'b1;
            cal_busy_o <= 1'b1;
            state_q <= ST_ALIGN;
          end
        end
        ST_ALIGN: begin
          // Begin on a slow edge so the window is whole periods
          cal_per_q <= 5'h00;
          cal_ref_q <= 32'h00000000;
          if (slow_tick_q) begin
            state_q <= ST_MEAS;
          end
        end
        ST_MEAS: begin
          if (ref_tick_q) begin
            cal_ref_q <= cal_ref_q + 32'h00000001;
          end
          if (slow_tick_q) begin
            if (cal_per_q == `SWT_CAL_PERIODS - 5'h01) begin
              // [RULE12] 20 periods give 10000 reference ticks at nominal
              cal_result_o <= cal_ref_q;
              cal_done_o <= 1'b1;
              cal_busy_o <= 1'b0;
              state_q <= ST_IDLE;
            end else begin
              cal_per_q <= cal_per_q + 5'h01;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // swt_top

// File: verif/swt_top_asserts.sv
module swt_top_asserts (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [1:0] stop_i,
  input wire logic [1:0] int_en_wr_i,
  input wire logic sleep_i,
  input wire logic [1:0] irq_ack_i,
  input wire logic cal_req_i,
  input wire logic [1:0] active_o,
  input wire logic [1:0] fired_o,
  input wire logic [1:0] irq_o,
  input wire logic wake_o,
  input wire logic cal_busy_o,
  input wire logic cal_done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Any command that may halt timer 1
  wire halt1 = stop_i[1] | int_en_wr_i[1];
  property p_stop; stop_i[0] |-> ##[1:3] !active_o[0]; endproperty
  a_stop: assert property (p_stop) else $error("stop left timer active");
  property p_quiet; stop_i[1] && !irq_o[1] |-> ##1 !irq_o[1] [*3]; endproperty
  a_quiet: assert property (p_quiet) else $error("stop raised irq");
  property p_hold; irq_o[1] && !irq_ack_i[1] |=> irq_o[1]; endproperty
  a_hold: assert property (p_hold) else $error("irq dropped unacked");
  property p_act; $fell(active_o[1]) |-> $past(halt1) || $past(halt1, 2) || $past(halt1, 3);
  endproperty
  a_act: assert property (p_act) else $error("active fell alone");
  property p_fire; $rose(fired_o[1]) |-> active_o[1]; endproperty
  a_fire: assert property (p_fire) else $error("idle timer fired");
  property p_wake; wake_o |-> $past(sleep_i); endproperty
  a_wake: assert property (p_wake) else $error("wake while awake");
  property p_done; cal_done_o |=> !cal_done_o; endproperty
  a_done: assert property (p_done) else $error("done not a pulse");
  property p_cal; cal_req_i && !cal_busy_o |-> ##[1:3] cal_busy_o; endproperty
  a_cal: assert property (p_cal) else $error("calibration not begun");
endmodule // swt_top_asserts

bind swt_top swt_top_asserts i_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .stop_i(stop_i),
  .int_en_wr_i(int_en_wr_i), .sleep_i(sleep_i), .irq_ack_i(irq_ack_i), .cal_req_i(cal_req_i),
  .active_o(active_o), .fired_o(fired_o), .irq_o(irq_o), .wake_o(wake_o),
  .cal_busy_o(cal_busy_o), .cal_done_o(cal_done_o));

// File: verif/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 3906;
  logic clk_i, reset_n_i, int_en_val_i, fired_rd_i, sleep_i, cal_req_i, wake_o;
  logic cal_busy_o, cal_done_o, wake_seen;
  logic [1:0] start_i, stop_i, int_en_wr_i, irq_ack_i, active_o, fired_o, irq_o;
  logic [40:0] load_count_i, cnt0, cnt1, ld;
  logic [31:0] res;
  int num_errors = 0;
  int checks_done = 0;
  int seed = 32'h5e39af8c;
  int n;
  swt_top i_swt_top (.clk_i(clk_i), .reset_n_i(reset_n_i), .start_i(start_i), .stop_i(stop_i),
    .load_count_i(load_count_i), .int_en_wr_i(int_en_wr_i), .int_en_val_i(int_en_val_i),
    .fired_rd_i(fired_rd_i), .sleep_i(sleep_i), .irq_ack_i(irq_ack_i), .cal_req_i(cal_req_i),
    .sleep_counter_first_o(cnt0), .sleep_counter_second_o(cnt1), .active_o(active_o),
    .fired_o(fired_o), .irq_o(irq_o), .wake_o(wake_o), .cal_busy_o(cal_busy_o),
    .cal_done_o(cal_done_o), .cal_result_o(res));
  initial begin
    clk_i = 0;
    forever #4 clk_i = ~clk_i;
  end
  // Wake is a one-cycle pulse, so latch it
  always @(posedge clk_i) if (wake_o === 1'b1) wake_seen <= 1'b1;
  // Next down-count value, with the 41'h1FFFFFFFF maximum reload past zero
  function automatic logic [40:0] nxt(logic [40:0] c);
    return c == 0 ? 41'h1FFFFFFFF : c - 1;
  endfunction
  task automatic cmp(input logic [40:0] got, input logic [40:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic pulse(ref logic [1:0] s, input logic [1:0] v);
    s = v;
    cyc(1);
    s = 0;
  endtask
  // Run is about 90k cycles; cut it off a little later
  initial begin
    #800000;
    num_errors++;
    results();
  end
  initial begin
    {start_i, stop_i, int_en_wr_i, irq_ack_i, int_en_val_i, fired_rd_i, sleep_i} = 0;
    {cal_req_i, wake_seen, reset_n_i, load_count_i} = 0;
    cyc(16);
    reset_n_i = 1;
    // Random start count kept within two and maximum
    ld = {$random(seed), $random(seed)} % 41'h1FFFFFFFE + 2;
    // Random and maximum counts on timer 0
    for (int i = 0; i < 2; i++) begin
      load_count_i = i ? 41'h1FFFFFFFF : ld;
      pulse(start_i, 2'b01);
      cyc(2);
      cmp(active_o[0], 1);
      for (n = 0; cnt0 === load_count_i && n < TK + 9; n++) cyc(1);
      cmp(cnt0, nxt(load_count_i));
      pulse(stop_i, 2'b01);
      cyc(3);
      cmp({active_o[0], irq_o[0]}, 0);
    end
    // Enable written before start; calibration runs alongside
    int_en_val_i = 1;
    pulse(int_en_wr_i, 2'b10);
    {load_count_i, sleep_i, cal_req_i} = {41'h2, 2'b11};
    pulse(start_i, 2'b10);
    cal_req_i = 0;
    cyc(2);
    // A plain stop raises nothing, and a restart still sees the stored enable
    pulse(stop_i, 2'b10);
    cyc(3);
    cmp({active_o[1], irq_o[1], wake_seen}, 0);
    pulse(start_i, 2'b10);
    for (n = 0; fired_o[1] !== 1'b1 && n < 3 * TK + 20; n++) cyc(1);
    cyc(2);
    cmp(irq_o[1], 1);
    cmp({wake_seen, active_o[1]}, 2'b11);
    cmp(cnt1, nxt(0));
    fired_rd_i = 1;
    cyc(1);
    fired_rd_i = 0;
    cyc(3);
    cmp({fired_o, irq_o[1]}, 3'b001);
    pulse(irq_ack_i, 2'b10);
    cyc(3);
    cmp(irq_o[1], 0);
    int_en_val_i = 0;
    pulse(int_en_wr_i, 2'b10);
    cyc(3);
    cmp(active_o[1], 0);
    // Restart with the enable clear: one count is one slow period, no wake on expiry
    wake_seen = 0;
    pulse(start_i, 2'b10);
    cyc(1);
    for (n = 0; cnt1 !== 41'h1 && n < TK + 9; n++) cyc(1);
    for (n = 0; cnt1 === 41'h1 && n < TK + 9; n++) cyc(1);
    cmp(n, TK);
    for (n = 0; fired_o[1] !== 1'b1 && n < TK + 20; n++) cyc(1);
    cyc(2);
    cmp({fired_o[1], irq_o[1], wake_seen}, 3'b100);
    pulse(stop_i, 2'b10);
    for (n = 0; cal_done_o !== 1'b1 && n < 22 * TK; n++) cyc(1);
    // A 3906-clock slow period is a hair fast of 32 kHz, so just under 10000
    cmp(res >= 9998 && res <= 10000, 1);
    cmp({active_o[0], cal_busy_o}, 2'b10);
    results();
  end
endmodule // tb
